// ==== design/pdc_pkg.sv ====
// Purpose: Shared constants for the program/debug instruction core.
// Assumes: Byte-wide serial link; control/status space of 16 byte locations.
// Notes: Opcodes and size fields follow the published instruction summary layout.
`default_nettype none
package pdc_pkg;
    // ----------------------------------------------------------------
    // Instruction opcodes, held in bits 7:5 of the instruction byte.
    // ----------------------------------------------------------------
    localparam logic [2:0] OP_LOAD_DIRECT = 3'h0;
    localparam logic [2:0] OP_LOAD_INDIRECT = 3'h1;
    localparam logic [2:0] OP_STORE_DIRECT = 3'h2;
    localparam logic [2:0] OP_STORE_INDIRECT = 3'h3;
    localparam logic [2:0] OP_LOAD_CTRL_SPACE = 3'h4;
    localparam logic [2:0] OP_REPEAT = 3'h5;
    localparam logic [2:0] OP_STORE_CTRL_SPACE = 3'h6;
    localparam logic [2:0] OP_KEY = 3'h7;

    // ----------------------------------------------------------------
    // Instruction byte fields.
    // ----------------------------------------------------------------
    localparam int OPC_LSB = 5;
    localparam int ASZ_LSB = 2;
    localparam int DSZ_LSB = 0;
    localparam int CSA_LSB = 0;

    // Pointer modes of the indirect instructions (bits 3:2).
    localparam logic [1:0] PM_AT_PTR = 2'h0;
    localparam logic [1:0] PM_AT_PTR_INC = 2'h1;
    localparam logic [1:0] PM_PTR_ITSELF = 2'h2;

    // ----------------------------------------------------------------
    // Control/status space offsets, fields and reset values.
    // ----------------------------------------------------------------
    localparam logic [3:0] CS_STATUS = 4'h0;
    localparam logic [3:0] CS_RESET = 4'h1;
    localparam logic [3:0] CS_CTRL = 4'h2;
    localparam int STATUS_MEMEN_BIT = 1;
    localparam int CTRL_GUARD_W = 3;
    localparam logic [7:0] RESET_SIGNATURE = 8'h59;
    localparam logic [2:0] CTRL_GUARD_RESET = 3'h0;
    localparam logic [2:0] GUARD_NONE = 3'h7;
    localparam logic [7:0] GUARD_MAX_BITS = 8'h80;

    // ----------------------------------------------------------------
    // Activation key.
    // ----------------------------------------------------------------
    localparam logic [63:0] ACTIVATION_KEY = 64'h1289AB45CDD888FF;
    localparam logic [31:0] KEY_LAST_INDEX = 32'h0000_0007;
endpackage
`default_nettype wire

// ==== design/pdc_core.sv ====
// Purpose: Instruction decode, pointer, repeat, key and control/status space of the debug port.
// Assumes: A physical layer on link_clk delivers checked bytes and exception pulses.
// Notes: Data-space accesses cross to mclk by toggle handshake; clk_en freezes both domains.
`default_nettype none

module pdc_core
    import pdc_pkg::*;
#(
    parameter int PTR_W = 32,
    parameter int RPT_W = 32
) (
    // Clocks, reset and enable.
    input wire logic mclk,
    input wire logic link_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Physical layer, link_clk domain.
    input wire logic iface_active,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic phy_error,
    input wire logic phy_break,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] turnaround_idle_bits,
    output logic in_error,
    // Internal access bus, mclk domain.
    output logic ibus_req,
    output logic ibus_we,
    output logic [PTR_W-1:0] ibus_addr,
    output logic [7:0] ibus_wdata,
    input wire logic [7:0] ibus_rdata,
    input wire logic ibus_ack,
    // System side, mclk domain.
    input wire logic other_reset_active,
    output logic memory_iface_enabled,
    output logic device_reset
);
    // ----------------------------------------------------------------
    // Sequencer states.
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_INSTR = 4'h0,
        S_ADDR = 4'h1,
        S_WDATA = 4'h2,
        S_RDREQ = 4'h3,
        S_BUSREQ = 4'h4,
        S_BUSWAIT = 4'h5,
        S_TX = 4'h6,
        S_RPT = 4'h7,
        S_KEY = 4'h8,
        S_DONE = 4'h9,
        S_ERR = 4'hA
    } pdc_state_t;

    // ----------------------------------------------------------------
    // Link domain registers. Only memen_r, rst_sig_r and guard_r have an address, in the control/status space.
    // ----------------------------------------------------------------
    pdc_state_t state_r;
    logic [7:0] instr_r;
    logic [PTR_W-1:0] ptr_r;
    logic [RPT_W-1:0] rpt_r;
    logic [1:0] opcnt_r;
    logic [63:0] key_r;
    logic memen_r;
    logic rst_sig_r;
    logic [CTRL_GUARD_W-1:0] guard_r;
    logic [7:0] wdata_r;
    logic req_tgl_r;
    logic [PTR_W-1:0] req_addr_r;
    logic [7:0] req_wdata_r;
    logic req_we_r;
    logic ack_s1_r, ack_s2_r, ack_s3_r, ack_seen_r;

    // mclk domain registers.
    logic req_s1_r, req_s2_r, req_s3_r, req_seen_r;
    logic ack_tgl_r;
    logic [7:0] rdata_r;
    logic mem_s1_r, mem_s2_r, mem_s3_r;
    logic rst_s1_r, rst_s2_r, rst_s3_r;

    // ----------------------------------------------------------------
    // Decode of the held instruction.
    // ----------------------------------------------------------------
    wire [2:0] opc = instr_r[OPC_LSB +: 3];
    wire [1:0] asz = instr_r[ASZ_LSB +: 2];
    wire [1:0] dsz = instr_r[DSZ_LSB +: 2];
    wire [3:0] cs_addr = instr_r[CSA_LSB +: 4];
    wire is_cs = (opc == OP_LOAD_CTRL_SPACE) || (opc == OP_STORE_CTRL_SPACE);
    wire is_indirect = (opc == OP_LOAD_INDIRECT) || (opc == OP_STORE_INDIRECT);
    wire is_store = (opc == OP_STORE_DIRECT) || (opc == OP_STORE_INDIRECT);
    wire ptr_itself = is_indirect && asz[1];
    wire post_inc = is_indirect && (asz == PM_AT_PTR_INC);
    wire size_done = (opcnt_r == dsz);
    wire can_repeat = (opc != OP_REPEAT) && (opc != OP_KEY);
    wire [PTR_W-1:0] access_addr = ptr_r + PTR_W'(opcnt_r);
    wire [PTR_W-1:0] ptr_inc = ptr_r + PTR_W'(dsz) + PTR_W'(1);
    wire [7:0] ptr_byte = ptr_r[{opcnt_r, 3'b000} +: 8];

    // Control/status read mux; reserved bits and offsets read zero.
    wire [7:0] cs_status = 8'(memen_r) << STATUS_MEMEN_BIT;
    wire [7:0] cs_reset = {7'h00, rst_sig_r};
    wire [7:0] cs_ctrl = {5'h00, guard_r};
    wire [7:0] cs_rdata = (cs_addr == CS_STATUS) ? cs_status :
                          (cs_addr == CS_RESET) ? cs_reset :
                          (cs_addr == CS_CTRL) ? cs_ctrl : 8'h00;

    // Handshake status of the crossing to mclk.
    wire ack_evt = (ack_s2_r == ack_s3_r) && (ack_s3_r != ack_seen_r);
    wire pending = (req_tgl_r != ack_seen_r);
    wire key_ok = ({rx_data, key_r[63:8]} == ACTIVATION_KEY);

    // First state of an execution of the given instruction byte.
    function automatic pdc_state_t first_state(input logic [7:0] ins);
        logic [2:0] o;
        o = ins[OPC_LSB +: 3];
        unique case (o)
            OP_LOAD_DIRECT, OP_STORE_DIRECT: first_state = S_ADDR;
            OP_LOAD_INDIRECT: first_state = S_RDREQ;
            OP_STORE_INDIRECT: first_state = S_WDATA;
            OP_LOAD_CTRL_SPACE: first_state = S_RDREQ;
            OP_STORE_CTRL_SPACE: first_state = S_WDATA;
            OP_REPEAT: first_state = S_RPT;
            OP_KEY: first_state = S_KEY;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Link domain sequencer.
    // ----------------------------------------------------------------
    // Exceptions beat every event but interface exit; a break seen outside the
    // error state is itself an exception, so two breaks resync from any state but S_ERR; from S_ERR the second break re-enters it.
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            state_r <= S_INSTR;
            instr_r <= 8'h00;
            ptr_r <= '0;
            rpt_r <= '0;
            opcnt_r <= 2'h0;
            key_r <= 64'h0;
            memen_r <= 1'b0;
            rst_sig_r <= 1'b0;
            guard_r <= CTRL_GUARD_RESET;
            wdata_r <= 8'h00;
            req_tgl_r <= 1'b0;
            req_addr_r <= '0;
            req_wdata_r <= 8'h00;
            req_we_r <= 1'b0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end else if (clk_en) begin
            if (!iface_active) begin
                state_r <= S_INSTR;
                instr_r <= 8'h00;
                ptr_r <= '0;
                rpt_r <= '0;
                opcnt_r <= 2'h0;
                key_r <= 64'h0;
                memen_r <= 1'b0;
                rst_sig_r <= 1'b0;
                guard_r <= CTRL_GUARD_RESET;
                tx_valid <= 1'b0;
            end else if (phy_error || (phy_break && state_r != S_ERR)) begin
                state_r <= S_ERR;
                tx_valid <= 1'b0;
            end else begin
                unique case (state_r)
                    S_INSTR: if (rx_valid) begin
                        instr_r <= rx_data;
                        opcnt_r <= 2'h0;
                        state_r <= first_state(rx_data);
                        if (rx_data[OPC_LSB +: 3] == OP_KEY) begin
                            rpt_r <= RPT_W'(KEY_LAST_INDEX);
                        end
                        if (rx_data[OPC_LSB +: 3] == OP_REPEAT) begin
                            rpt_r <= '0;
                        end
                    end
                    S_ADDR: if (rx_valid) begin
                        ptr_r[{opcnt_r, 3'b000} +: 8] <= rx_data;
                        opcnt_r <= (opcnt_r == asz) ? 2'h0 : opcnt_r + 2'h1;
                        if (opcnt_r == asz) begin
                            state_r <= is_store ? S_WDATA : S_RDREQ;
                        end
                    end
                    S_WDATA: if (rx_valid) begin
                        if (opc == OP_STORE_CTRL_SPACE) begin
                            state_r <= S_DONE;
                            if (cs_addr == CS_STATUS) begin
                                memen_r <= 1'b0;
                            end
                            if (cs_addr == CS_RESET) begin
                                rst_sig_r <= (rx_data == RESET_SIGNATURE);
                            end
                            if (cs_addr == CS_CTRL) begin
                                guard_r <= rx_data[CTRL_GUARD_W-1:0];
                            end
                        end else if (ptr_itself) begin
                            ptr_r[{opcnt_r, 3'b000} +: 8] <= rx_data;
                            opcnt_r <= size_done ? opcnt_r : opcnt_r + 2'h1;
                            state_r <= size_done ? S_DONE : S_WDATA;
                        end else begin
                            wdata_r <= rx_data;
                            state_r <= S_BUSREQ;
                        end
                    end
                    S_RDREQ: begin
                        if (opc == OP_LOAD_CTRL_SPACE) begin
                            tx_data <= cs_rdata;
                            tx_valid <= 1'b1;
                            state_r <= S_TX;
                        end else if (ptr_itself) begin
                            tx_data <= ptr_byte;
                            tx_valid <= 1'b1;
                            state_r <= S_TX;
                        end else begin
                            state_r <= S_BUSREQ;
                        end
                    end
                    S_BUSREQ: if (!pending) begin
                        req_addr_r <= access_addr;
                        req_wdata_r <= wdata_r;
                        req_we_r <= is_store;
                        req_tgl_r <= ~req_tgl_r;
                        state_r <= S_BUSWAIT;
                    end
                    S_BUSWAIT: if (ack_evt) begin
                        if (is_store) begin
                            opcnt_r <= size_done ? opcnt_r : opcnt_r + 2'h1;
                            state_r <= size_done ? S_DONE : S_WDATA;
                        end else begin
                            tx_data <= rdata_r;
                            tx_valid <= 1'b1;
                            state_r <= S_TX;
                        end
                    end
                    S_TX: if (tx_ready) begin
                        tx_valid <= 1'b0;
                        if (is_cs || size_done) begin
                            state_r <= S_DONE;
                        end else begin
                            opcnt_r <= opcnt_r + 2'h1;
                            state_r <= S_RDREQ;
                        end
                    end
                    S_RPT: if (rx_valid) begin
                        rpt_r[{opcnt_r, 3'b000} +: 8] <= rx_data;
                        opcnt_r <= size_done ? opcnt_r : opcnt_r + 2'h1;
                        state_r <= size_done ? S_INSTR : S_RPT;
                    end
                    S_KEY: if (rx_valid) begin
                        key_r <= {rx_data, key_r[63:8]};
                        if (rpt_r == '0) begin
                            memen_r <= memen_r | key_ok;
                            state_r <= S_INSTR;
                        end else begin
                            rpt_r <= rpt_r - RPT_W'(1);
                        end
                    end
                    S_DONE: begin
                        if (post_inc) begin
                            ptr_r <= ptr_inc;
                        end
                        opcnt_r <= 2'h0;
                        if (can_repeat && rpt_r != '0) begin
                            rpt_r <= rpt_r - RPT_W'(1);
                            state_r <= first_state(instr_r);
                        end else begin
                            state_r <= S_INSTR;
                        end
                    end
                    S_ERR: if (phy_break) begin
                        state_r <= S_INSTR;
                    end
                    default: state_r <= S_ERR;
                endcase
            end
        end
    end

    // Guard-time count for the receive-to-transmit turnaround only; the
    // physical layer applies none when it turns back to receive.
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            turnaround_idle_bits <= GUARD_MAX_BITS;
        end else if (clk_en) begin
            turnaround_idle_bits <= (guard_r == GUARD_NONE) ? 8'h00 : (GUARD_MAX_BITS >> guard_r);
        end
    end

    assign in_error = (state_r == S_ERR);

    // Acknowledge toggle from mclk: three stages, counted when two agree.
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end else if (clk_en) begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
            if (ack_evt) begin
                ack_seen_r <= ack_s3_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // mclk domain: request crossing and internal bus access.
    // ----------------------------------------------------------------
    // The link side holds address and data steady until the answer
    // returns, so they are sampled once the request toggle settles.
    wire req_evt = (req_s2_r == req_s3_r) && (req_s3_r != req_seen_r);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            req_seen_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            rdata_r <= 8'h00;
            ibus_req <= 1'b0;
            ibus_we <= 1'b0;
            ibus_addr <= '0;
            ibus_wdata <= 8'h00;
        end else if (clk_en) begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            if (req_evt) begin
                req_seen_r <= req_s3_r;
                ibus_req <= 1'b1;
                ibus_we <= req_we_r;
                ibus_addr <= req_addr_r;
                ibus_wdata <= req_wdata_r;
            end else if (ibus_req && ibus_ack) begin
                ibus_req <= 1'b0;
                rdata_r <= ibus_rdata;
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    // Level crossings of memory enable and reset request.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mem_s1_r <= 1'b0;
            mem_s2_r <= 1'b0;
            mem_s3_r <= 1'b0;
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
            rst_s3_r <= 1'b0;
            memory_iface_enabled <= 1'b0;
            device_reset <= 1'b0;
        end else if (clk_en) begin
            mem_s1_r <= memen_r;
            mem_s2_r <= mem_s1_r;
            mem_s3_r <= mem_s2_r;
            rst_s1_r <= rst_sig_r;
            rst_s2_r <= rst_s1_r;
            rst_s3_r <= rst_s2_r;
            if (mem_s2_r == mem_s3_r) begin
                memory_iface_enabled <= mem_s3_r;
            end
            if (rst_s2_r == rst_s3_r) begin
                device_reset <= rst_s3_r | other_reset_active;
            end else begin
                device_reset <= device_reset | other_reset_active;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/pdc_core_chk.sv ====
// Purpose: Port-level checks for pdc_core.
// Assumes: Both clock domains are cleared by reset.
// Notes: Bound to every pdc_core instance.
`default_nettype none
module pdc_core_chk #(parameter int PTR_W = 32) (
    // Clocks, reset and enables.
    input wire logic mclk, link_clk, reset, clk_en, iface_active,
    // Link side.
    input wire logic phy_error, phy_break, tx_valid, tx_ready, in_error,
    input wire logic [7:0] tx_data, turnaround_idle_bits,
    // Bus and system side.
    input wire logic ibus_req, ibus_we, ibus_ack, other_reset_active, device_reset,
    input wire logic [7:0] ibus_wdata,
    input wire logic [PTR_W-1:0] ibus_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // The link logic only steps while it is enabled and entered.
    wire run = clk_en && iface_active;
    // A byte offered but not yet taken, and an error state not yet broken.
    sequence s_tx_wait;
        tx_valid && !tx_ready && iface_active;
    endsequence
    sequence s_err_wait;
        in_error && !phy_break && iface_active;
    endsequence
    AST_TX_HOLD: assert property (@(posedge link_clk) disable iff (reset) s_tx_wait |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before accept");
    AST_TX_DROP: assert property (@(posedge link_clk) disable iff (reset) run && tx_valid && tx_ready |=> !tx_valid)
        else $error("tx valid held after accept");
    AST_GUARD_SET: assert property (@(posedge link_clk) disable iff (reset) $onehot0(turnaround_idle_bits) && !turnaround_idle_bits[0])
        else $error("idle bit count not a legal setting");
    AST_ERR_ENTER: assert property (@(posedge link_clk) disable iff (reset) run && phy_error |=> in_error)
        else $error("exception did not enter error state");
    AST_ERR_STAY: assert property (@(posedge link_clk) disable iff (reset) s_err_wait |=> in_error)
        else $error("error state left without break");
    AST_ERR_LEAVE: assert property (@(posedge link_clk) disable iff (reset) run && in_error && phy_break |=> !in_error)
        else $error("break did not leave error state");
    AST_BUS_HOLD: assert property (@(posedge mclk) disable iff (reset)
        ibus_req && !ibus_ack |=> ibus_req && $stable({ibus_we, ibus_addr, ibus_wdata}))
        else $error("bus request changed before ack");
    AST_BUS_DROP: assert property (@(posedge mclk) disable iff (reset) clk_en && ibus_req && ibus_ack |=> !ibus_req)
        else $error("bus request held after ack");
    AST_OTHER_RST: assert property (@(posedge mclk) disable iff (reset) clk_en && other_reset_active |-> ##[0:1] device_reset)
        else $error("other reset source not passed on");
endmodule
bind pdc_core pdc_core_chk #(.PTR_W(PTR_W)) u_chk (.mclk(mclk), .link_clk(link_clk), .reset(reset),
    .clk_en(clk_en), .iface_active(iface_active), .phy_error(phy_error), .phy_break(phy_break),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .in_error(in_error), .tx_data(tx_data),
    .turnaround_idle_bits(turnaround_idle_bits), .ibus_req(ibus_req), .ibus_we(ibus_we), .ibus_ack(ibus_ack),
    .other_reset_active(other_reset_active), .device_reset(device_reset), .ibus_wdata(ibus_wdata),
    .ibus_addr(ibus_addr));
`default_nettype wire

// ==== verif/pdc_prog_model.sv ====
// Purpose: Programmer side of the link, at byte level.
// Assumes: Driven at the falling edge of link_clk.
// Notes: Released data shows the inverse of the last byte.
`default_nettype none
module pdc_prog_model (
    // Link pins.
    input wire logic link_clk,
    output logic [7:0] rx_data,
    output logic rx_valid, phy_error, phy_break, tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet link at start.
    initial begin
        rx_data = 8'hFF;
        rx_valid = 1'b0;
        phy_error = 1'b0;
        phy_break = 1'b0;
        tx_ready = 1'b0;
    end
    // One byte, then a long gap so any bus access behind it can finish.
    task automatic send(input logic [7:0] v);
        @(negedge link_clk);
        rx_data = v;
        rx_valid = 1'b1;
        @(negedge link_clk);
        rx_valid = 1'b0;
        rx_data = ~v;
        repeat (12) @(negedge link_clk);
    endtask
    // Exception or break pulse.
    task automatic pulse(input logic brk);
        @(negedge link_clk);
        phy_break = brk;
        phy_error = !brk;
        @(negedge link_clk);
        phy_break = 1'b0;
        phy_error = 1'b0;
        repeat (4) @(negedge link_clk);
    endtask
    // Waits for a byte, stalls for slow cycles, then takes it.
    task automatic recv(input int slow, output logic [7:0] v, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(negedge link_clk);
            ok = (tx_valid === 1'b1);
        end
        repeat (slow) @(negedge link_clk);
        tx_ready = 1'b1;
        @(posedge link_clk);
        v = tx_data;
        @(negedge link_clk);
        tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/program_debug_instruction_core_test.sv ====
// Purpose: Self-checking bench for pdc_core.
// Assumes: The bus partner acks each access one cycle after it shows.
// Notes: Clock enable and interface entry each drop once.
`default_nettype none
module program_debug_instruction_core_test
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, link_clk = 0, reset, clk_en, iface_active, ibus_ack, other_reset_active;
    logic rx_valid, phy_error, phy_break, tx_ready, tx_valid, in_error, ibus_req, ibus_we;
    logic memory_iface_enabled, device_reset, ok;
    logic [7:0] ibus_rdata, rx_data, tx_data, turnaround_idle_bits, ibus_wdata, b, wd;
    logic [31:0] ibus_addr, ad;
    int error_cnt = 0, total_checks = 0, cycles = 0, writes = 0;
    pdc_core uut (.*);
    pdc_prog_model prog (.*);
    // System clock, and a link clock offset so its edges never meet mclk edges.
    always #5 mclk = ~mclk;
    initial #3 forever #80 link_clk = ~link_clk;
    // Bus partner: one-cycle ack, last access kept for checking.
    always @(negedge mclk) begin
        ibus_ack <= ibus_req && !ibus_ack;
        if (ibus_req && !ibus_ack) begin
            ad <= ibus_addr;
            wd <= ibus_wdata;
            writes <= writes + ibus_we;
        end
        ibus_rdata <= ibus_req ? 8'hA5 : ~ibus_rdata;
    end
    // A hang counts as a mismatch.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [39:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cs_write(input logic [3:0] a, input logic [7:0] v);
        prog.send({OP_STORE_CTRL_SPACE, 1'b0, a});
        prog.send(v);
    endtask
    task automatic cs_read(input logic [3:0] a, input logic [7:0] exp, input string what);
        prog.send({OP_LOAD_CTRL_SPACE, 1'b0, a});
        prog.recv(0, b, ok);
        chk({ok, b}, {1'b1, exp}, what);
    endtask
    task automatic send_key(input logic [63:0] k);
        prog.send({OP_KEY, 5'h00});
        for (int i = 0; i < 8; i++)
            prog.send(k[8*i +: 8]);
    endtask
    task automatic t_guard();
        for (int g = 0; g < 8; g++) begin
            cs_write(CS_CTRL, 8'(g));
            chk(turnaround_idle_bits, (g == 7) ? 8'h00 : GUARD_MAX_BITS >> g, "idle bits");
        end
        cs_write(CS_CTRL, 8'hFD);
        prog.send({OP_LOAD_CTRL_SPACE, 1'b0, CS_CTRL});
        prog.recv(6, b, ok);
        chk({ok, b}, 9'h105, "slow ctrl read");
    endtask
    task automatic t_error();
        prog.pulse(1'b0);
        chk(in_error, 1'b1, "error entry");
        cs_write(CS_CTRL, 8'h00);
        chk(turnaround_idle_bits, 8'h04, "ignored bytes");
        prog.pulse(1'b1);
        chk(in_error, 1'b0, "break exit");
        cs_read(CS_CTRL, 8'h05, "ctrl after break");
        clk_en = 1'b0;
        cs_write(CS_CTRL, 8'h00);
        clk_en = 1'b1;
        chk(turnaround_idle_bits, 8'h04, "frozen");
        iface_active = 1'b0;
        prog.pulse(1'b1);
        iface_active = 1'b1;
        cs_read(CS_CTRL, 8'h00, "exit");
    endtask
    task automatic t_reset_reg();
        cs_write(CS_RESET, RESET_SIGNATURE);
        chk(device_reset, 1'b1, "reset forced");
        cs_read(CS_RESET, 8'h01, "reset state");
        @(negedge mclk);
        other_reset_active = 1'b1;
        cs_write(CS_RESET, 8'h00);
        chk(device_reset, 1'b1, "other source");
        other_reset_active = 1'b0;
        repeat (5) @(negedge mclk);
        chk(device_reset, 1'b0, "reset released");
        cs_read(CS_RESET, 8'h00, "reset cleared");
    endtask
    task automatic t_key();
        send_key(ACTIVATION_KEY ^ 64'h1);
        chk(memory_iface_enabled, 1'b0, "wrong key");
        prog.send({OP_REPEAT, 5'h00});
        prog.send(8'h05);
        send_key(ACTIVATION_KEY);
        chk(memory_iface_enabled, 1'b1, "right key");
        cs_read(CS_STATUS, 8'h02, "status");
        repeat (4) @(negedge link_clk);
        chk(tx_valid, 1'b0, "read not repeated");
        cs_write(CS_STATUS, 8'h00);
        chk(memory_iface_enabled, 1'b0, "enable cleared");
    endtask
    task automatic t_ptr();
        int w;
        prog.send({OP_STORE_INDIRECT, 1'b0, PM_PTR_ITSELF, 2'h1});
        prog.send(8'h34);
        prog.send(8'h12);
        cs_write(CS_CTRL, 8'h07);
        prog.send({OP_LOAD_INDIRECT, 1'b0, PM_PTR_ITSELF, 2'h1});
        prog.recv(0, b, ok);
        chk(b, 8'h34, "ptr low");
        prog.recv(0, b, ok);
        chk(b, 8'h12, "ptr high");
        prog.send({OP_STORE_INDIRECT, 1'b0, PM_PTR_ITSELF, 2'h0});
        prog.send(8'h77);
        w = writes;
        prog.send({OP_REPEAT, 5'h00});
        prog.send(8'h01);
        prog.send({OP_STORE_INDIRECT, 1'b0, PM_AT_PTR_INC, 2'h0});
        prog.send(8'hAB);
        prog.send(8'hCD);
        chk(writes - w, 2, "repeat runs");
        chk({ad, wd}, 40'h00001278CD, "post increment");
        prog.send({OP_STORE_DIRECT, 1'b0, 2'h0, 2'h0});
        prog.send(8'h3C);
        prog.send(8'h96);
        chk({ad, wd}, 40'h0000123C96, "direct store");
        prog.send({OP_LOAD_DIRECT, 1'b0, 4'h0});
        prog.send(8'h5A);
        prog.recv(0, b, ok);
        chk({b, ad}, 40'hA50000125A, "load");
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        {reset, clk_en, iface_active, other_reset_active} = 4'hE;
        repeat (2) @(posedge link_clk);
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge link_clk);
        chk(turnaround_idle_bits, 8'h80, "idle bits at reset");
        cs_read(CS_CTRL, 8'h00, "ctrl at reset");
        cs_read(CS_STATUS, 8'h00, "status at reset");
        t_guard();
        t_error();
        t_reset_reg();
        t_key();
        t_ptr();
        end_sim();
    end
endmodule
`default_nettype wire
